// ==== dpr_block.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "dpr_defs.svh"
`default_nettype none
module dpr_block (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic [11:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire dpr_pkg::dpr_word_t s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [11:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output dpr_pkg::dpr_word_t s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	import dpr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Storage: 512 words x (8 data + 1 parity) bits per lane row
	logic [8:0] mem [0:`DPR_WORDS-1];
	logic [12:0] ctrl_q;
	logic [11:0] addr_a_q, addr_b_q;
	logic [35:0] wdat_a_q, wdat_b_q;
	logic [3:0] ben_a_q, ben_b_q;
	logic [1:0] cmd_a_q, cmd_b_q;
	logic [31:0] init_q;
	logic cfg_err_q, wr_ref_q, fifo_err_q;
	// Input register stage
	logic [11:0] ia_a_q, ia_b_q;
	logic [35:0] id_a_q, id_b_q;
	logic [3:0] ib_a_q, ib_b_q;
	logic iw_a_q, iw_b_q, ir_a_q, ir_b_q;
	// Read stages
	logic [35:0] rd_a_q, rd_b_q, or_a_q, or_b_q;
	logic rv_a_q, rv_b_q;

	dpr_mode_e mode;
	dpr_width_e wid;
	assign mode = dpr_mode_e'(ctrl_q[`DPR_CTRL_MODE_MSB:`DPR_CTRL_MODE_LSB]);
	assign wid = dpr_width_e'(ctrl_q[`DPR_CTRL_WID_MSB:`DPR_CTRL_WID_LSB]);

	// Lanes per word for a width: 9-bit rows, 1..4
	function automatic logic [2:0] lanes(input dpr_width_e w);
		case (w)
			DPR_W16, DPR_W18: lanes = 3'd2;
			DPR_W32, DPR_W36: lanes = 3'd4;
			default: lanes = 3'd1;
		endcase
	endfunction

	// Sub-lane bits for narrow widths
	function automatic logic [3:0] nbits(input dpr_width_e w);
		case (w)
			DPR_W1: nbits = 4'd1;
			DPR_W2: nbits = 4'd2;
			DPR_W4: nbits = 4'd4;
			DPR_W8, DPR_W16, DPR_W32: nbits = 4'd8;
			default: nbits = 4'd9;
		endcase
	endfunction

	function automatic logic [3:0] sub_sh(input dpr_width_e w);
		case (w)
			DPR_W1: sub_sh = 4'd3;
			DPR_W2: sub_sh = 4'd2;
			DPR_W4: sub_sh = 4'd1;
			default: sub_sh = 4'd0;
		endcase
	endfunction

	logic cfg_bad;
	assign cfg_bad = (wid > DPR_W36) || (mode > DPR_FIFO)
		|| ((mode == DPR_TRUE_DUAL) && (wid == DPR_W32 || wid == DPR_W36));

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic aw_hold_q, w_hold_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_wr;
	logic [11:0] ar_q;
	assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid_out;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
	endfunction

	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `DPR_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_wr)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (awaddr_q > `DPR_REG_INIT) ? `DPR_RESP_SLVERR : `DPR_RESP_OKAY;
			end
			if (s_axi_bvalid_out && s_axi_bready_in)
			begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	// Software-written registers; command strobes self-clear
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_q <= 13'h0000;
			addr_a_q <= 12'h000;
			addr_b_q <= 12'h000;
			wdat_a_q <= 36'h0_0000_0000;
			wdat_b_q <= 36'h0_0000_0000;
			ben_a_q <= 4'hF;
			ben_b_q <= 4'hF;
			cmd_a_q <= 2'b00;
			cmd_b_q <= 2'b00;
			init_q <= 32'h0000_0000;
		end
		else
		begin
			cmd_a_q <= 2'b00;
			cmd_b_q <= 2'b00;
			ctrl_q[`DPR_CTRL_CLR] <= 1'b0;
			init_q[`DPR_INIT_GO] <= 1'b0;
			if (do_wr)
			begin
				if (awaddr_q == `DPR_REG_CTRL)
					ctrl_q <= 13'(merge({19'h0, ctrl_q}, wdata_q, wstrb_q));
				else if (awaddr_q == `DPR_REG_ADDR_A)
					addr_a_q <= 12'(merge({20'h0, addr_a_q}, wdata_q, wstrb_q));
				else if (awaddr_q == `DPR_REG_WDATA_A)
					wdat_a_q <= {wdat_a_q[35:32], merge(wdat_a_q[31:0], wdata_q, wstrb_q)};
				else if (awaddr_q == `DPR_REG_BEN_A)
					{wdat_a_q[35:32], ben_a_q} <= wdata_q[7:0];
				else if (awaddr_q == `DPR_REG_CMD_A)
					cmd_a_q <= wdata_q[1:0];
				else if (awaddr_q == `DPR_REG_ADDR_B)
					addr_b_q <= 12'(merge({20'h0, addr_b_q}, wdata_q, wstrb_q));
				else if (awaddr_q == `DPR_REG_WDATA_B)
					wdat_b_q <= {wdat_b_q[35:32], merge(wdat_b_q[31:0], wdata_q, wstrb_q)};
				else if (awaddr_q == `DPR_REG_BEN_B)
					{wdat_b_q[35:32], ben_b_q} <= wdata_q[7:0];
				else if (awaddr_q == `DPR_REG_CMD_B)
					cmd_b_q <= wdata_q[1:0];
				else if (awaddr_q == `DPR_REG_INIT)
					init_q <= wdata_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input registers, always present
	logic hold_a, hold_b, rom_mode;
	assign hold_a = ctrl_q[`DPR_CTRL_ACE_A];
	assign hold_b = ctrl_q[`DPR_CTRL_ACE_B];
	assign rom_mode = (mode == DPR_ROM);
	// Port B writes in dual and FIFO modes or as the packed upper half
	logic wr_ok_a, wr_ok_b;
	assign wr_ok_a = !rom_mode && !cfg_bad && mode != DPR_SIMPLE_DUAL;
	assign wr_ok_b = !rom_mode && !cfg_bad && (mode != DPR_SINGLE || ctrl_q[`DPR_CTRL_PACK]);

	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ia_a_q <= 12'h000;
			ia_b_q <= 12'h000;
			id_a_q <= 36'h0_0000_0000;
			id_b_q <= 36'h0_0000_0000;
			ib_a_q <= 4'h0;
			ib_b_q <= 4'h0;
			{iw_a_q, iw_b_q, ir_a_q, ir_b_q} <= 4'h0;
		end
		else
		begin
			if (!hold_a)
				ia_a_q <= addr_a_q;
			if (!hold_b)
				ia_b_q <= addr_b_q;
			id_a_q <= wdat_a_q;
			id_b_q <= wdat_b_q;
			ib_a_q <= ben_a_q;
			ib_b_q <= ben_b_q;
			// ROM and bad shapes refuse writes
			iw_a_q <= cmd_a_q[`DPR_CMD_WR] && wr_ok_a;
			iw_b_q <= cmd_b_q[`DPR_CMD_WR] && wr_ok_b;
			ir_a_q <= cmd_a_q[`DPR_CMD_RD] && !cfg_bad;
			ir_b_q <= cmd_b_q[`DPR_CMD_RD] && !cfg_bad && (mode != DPR_SINGLE || ctrl_q[`DPR_CTRL_PACK]);
		end
	end

	// Row and lane for a port: packed halves split on the top row bit
	function automatic logic [`DPR_AW-1:0] row_of(input logic [11:0] a, input dpr_width_e w,
		input logic [2:0] ln, input int i, input logic pk, input logic hi);
		logic [11:0] r;
		r = (a >> sub_sh(w)) * ln + 12'(i);
		if (pk)
			r = {3'b000, hi, r[`DPR_HALF_AW-1:0]};
		row_of = r[`DPR_AW-1:0];
	endfunction

	logic [2:0] ln;
	assign ln = lanes(wid);

	////////////////////////////////////////////////////////////////////////////
	// Memory array with byte masking; old data read by the other port
	always_ff @(posedge sys_clk_in)
	begin
		if (init_q[`DPR_INIT_GO])
			mem[init_q[8+`DPR_AW:9]] <= init_q[8:0];
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (iw_a_q && i < ln && ib_a_q[i])
					mem[row_of(ia_a_q, wid, ln, i, ctrl_q[`DPR_CTRL_PACK], 1'b0)] <=
						(nbits(wid) >= 4'd8) ? id_a_q[i*9 +: 9] : 9'(id_a_q[7:0]) << 0;
				if (iw_b_q && i < ln && ib_b_q[i])
					mem[row_of(ia_b_q, wid, ln, i, ctrl_q[`DPR_CTRL_PACK], 1'b1)] <= id_b_q[i*9 +: 9];
			end
		end
	end

	// Read: same-port write forwards new data, other-port write leaves old data
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rd_a_q <= 36'h0_0000_0000;
			rd_b_q <= 36'h0_0000_0000;
			rv_a_q <= 1'b0;
			rv_b_q <= 1'b0;
		end
		else
		begin
			rv_a_q <= ir_a_q;
			rv_b_q <= ir_b_q;
			for (int i = 0; i < 4; i++)
			begin
				if (ir_a_q && i < ln)
					rd_a_q[i*9 +: 9] <= (iw_a_q && ib_a_q[i]) ? id_a_q[i*9 +: 9]
						: mem[row_of(ia_a_q, wid, ln, i, ctrl_q[`DPR_CTRL_PACK], 1'b0)];
				if (ir_b_q && i < ln)
					rd_b_q[i*9 +: 9] <= (iw_b_q && ib_b_q[i]) ? id_b_q[i*9 +: 9]
						: mem[row_of(ia_b_q, wid, ln, i, ctrl_q[`DPR_CTRL_PACK], 1'b1)];
			end
		end
	end

	// Output register stage, loads on new read data; a clear holds until the next read
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			or_a_q <= 36'h0_0000_0000;
			or_b_q <= 36'h0_0000_0000;
		end
		else if (ctrl_q[`DPR_CTRL_CLR])
		begin
			or_a_q <= 36'h0_0000_0000;
			or_b_q <= 36'h0_0000_0000;
		end
		else
		begin
			if (rv_a_q)
				or_a_q <= rd_a_q;
			if (rv_b_q)
				or_b_q <= rd_b_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status; sticky flags, set wins, cleared by write to STAT
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cfg_err_q <= 1'b0;
			wr_ref_q <= 1'b0;
			fifo_err_q <= 1'b0;
		end
		else
		begin
			if (do_wr && awaddr_q == `DPR_REG_STAT)
				{fifo_err_q, wr_ref_q, cfg_err_q} <= 3'b000;
			if (cfg_bad)
				cfg_err_q <= 1'b1;
			if ((cmd_a_q[`DPR_CMD_WR] && !wr_ok_a) || (cmd_b_q[`DPR_CMD_WR] && !wr_ok_b))
				wr_ref_q <= 1'b1;
			if (mode == DPR_FIFO && cmd_a_q == 2'b11 && cmd_b_q == 2'b11)
				fifo_err_q <= 1'b1;
		end
	end

	logic [35:0] out_a, out_b;
	assign out_a = ctrl_q[`DPR_CTRL_OREG] ? or_a_q : rd_a_q;
	assign out_b = ctrl_q[`DPR_CTRL_OREG] ? or_b_q : rd_b_q;

	// Read channel
	always_ff @(posedge sys_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= `DPR_RESP_OKAY;
			ar_q <= 12'h000;
		end
		else
		begin
			if (s_axi_arvalid_in && s_axi_arready_out)
			begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= `DPR_RESP_OKAY;
				ar_q <= s_axi_araddr_in;
				if (s_axi_araddr_in == `DPR_REG_CTRL)
					s_axi_rdata_out <= {19'h0, ctrl_q};
				else if (s_axi_araddr_in == `DPR_REG_STAT)
					s_axi_rdata_out <= {16'(`DPR_TOTAL_BITS), 8'h00, rv_b_q, rv_a_q, 3'b000,
						fifo_err_q, wr_ref_q, cfg_err_q};
				else if (s_axi_araddr_in == `DPR_REG_ADDR_A)
					s_axi_rdata_out <= {20'h0, ia_a_q};
				else if (s_axi_araddr_in == `DPR_REG_RDATA_A)
					s_axi_rdata_out <= out_a[31:0];
				else if (s_axi_araddr_in == `DPR_REG_BEN_A)
					s_axi_rdata_out <= {24'h0, out_a[35:32], ben_a_q};
				else if (s_axi_araddr_in == `DPR_REG_ADDR_B)
					s_axi_rdata_out <= {20'h0, ia_b_q};
				else if (s_axi_araddr_in == `DPR_REG_RDATA_B)
					s_axi_rdata_out <= out_b[31:0];
				else if (s_axi_araddr_in == `DPR_REG_BEN_B)
					s_axi_rdata_out <= {24'h0, out_b[35:32], ben_b_q};
				else if (s_axi_araddr_in <= `DPR_REG_INIT)
					s_axi_rdata_out <= 32'h0000_0000;
				else
				begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= `DPR_RESP_SLVERR;
				end
			end
			if (s_axi_rvalid_out && s_axi_rready_in)
			begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_tdp_refuse;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		(mode == DPR_TRUE_DUAL && wid == DPR_W36 && cmd_a_q[`DPR_CMD_WR]) |=> !iw_a_q;
	endproperty
	a_tdp_refuse: assert property (p_tdp_refuse) else $error("wide shape write in true dual");

	property p_clr_out;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		ctrl_q[`DPR_CTRL_CLR] |=> (or_a_q == 36'h0_0000_0000 && or_b_q == 36'h0_0000_0000);
	endproperty
	a_clr_out: assert property (p_clr_out) else $error("clear did not zero outputs");

	property p_oreg;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		!ctrl_q[`DPR_CTRL_CLR] |=> or_a_q == ($past(rv_a_q) ? $past(rd_a_q) : $past(or_a_q));
	endproperty
	a_oreg: assert property (p_oreg) else $error("output stage lost data");

	property p_ace_hold;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		hold_a |=> ia_a_q == $past(ia_a_q);
	endproperty
	a_ace_hold: assert property (p_ace_hold) else $error("address moved under hold");

	property p_same_port;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		(ir_a_q && iw_a_q && ib_a_q[0]) |=> rd_a_q[8:0] == $past(id_a_q[8:0]);
	endproperty
	a_same_port: assert property (p_same_port) else $error("same-port read not new data");

	property p_rom_nowr;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		rom_mode |=> !iw_a_q && !iw_b_q;
	endproperty
	a_rom_nowr: assert property (p_rom_nowr) else $error("write accepted in ROM");

	property p_fifo_flag;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		(mode == DPR_FIFO && cmd_a_q == 2'b11 && cmd_b_q == 2'b11) |=> fifo_err_q;
	endproperty
	a_fifo_flag: assert property (p_fifo_flag) else $error("fifo misuse not flagged");

	property p_in_reg;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		1'b1 |=> id_a_q == $past(wdat_a_q);
	endproperty
	a_in_reg: assert property (p_in_reg) else $error("input register skipped");

	c_wr: cover property (@(posedge sys_clk_in) do_wr);
	c_rw: cover property (@(posedge sys_clk_in) iw_a_q && ir_b_q);
	c_tdp: cover property (@(posedge sys_clk_in) mode == DPR_TRUE_DUAL && iw_a_q && iw_b_q);
endmodule
`default_nettype wire

// ==== dpr_block_tb.sv ====
`include "dpr_defs.svh"
`default_nettype none
module dpr_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dpr_pkg::*;
`define CHK(what, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end
	logic sys_clk_in;
	logic nrst_in;
	logic [11:0] s_axi_awaddr_in;
	logic s_axi_awvalid_in;
	logic s_axi_awready_out;
	dpr_word_t s_axi_wdata_in;
	logic [3:0] s_axi_wstrb_in;
	logic s_axi_wvalid_in;
	logic s_axi_wready_out;
	logic [1:0] s_axi_bresp_out;
	logic s_axi_bvalid_out;
	logic s_axi_bready_in;
	logic [11:0] s_axi_araddr_in;
	logic s_axi_arvalid_in;
	logic s_axi_arready_out;
	dpr_word_t s_axi_rdata_out;
	logic [1:0] s_axi_rresp_out;
	logic s_axi_rvalid_out;
	logic s_axi_rready_in;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [1:0] resp;
	dpr_word_t rd_v;
	dpr_block u_dpr_block (.sys_clk_in, .nrst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
	dpr_user_model u_dpr_user_model (.sys_clk_in(sys_clk_in), .awaddr_out(s_axi_awaddr_in),
		.awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out), .wdata_out(s_axi_wdata_in),
		.wstrb_out(s_axi_wstrb_in), .wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out),
		.bresp_in(s_axi_bresp_out), .bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in),
		.araddr_out(s_axi_araddr_in), .arvalid_out(s_axi_arvalid_in), .arready_in(s_axi_arready_out),
		.rdata_in(s_axi_rdata_out), .rresp_in(s_axi_rresp_out), .rvalid_in(s_axi_rvalid_out),
		.rready_out(s_axi_rready_in));
	////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [11:0] a, input dpr_word_t d);
		u_dpr_user_model.wr(a, d, resp);
	endtask
	task automatic reg_rd(input logic [11:0] a);
		u_dpr_user_model.rd(a, rd_v, resp);
	endtask
	function automatic dpr_word_t ctrl(input logic [2:0] m, input logic [3:0] w, input logic [4:0] ex);
		return {19'h0, ex, w, 1'b0, m};
	endfunction
	// Load address, data, enables, then strobe the command
	task automatic mem_op(input logic b, input logic [8:0] a, input logic [7:0] d, input logic [3:0] be,
		input logic [1:0] cmd);
		logic [11:0] o;
		o = b ? 12'h014 : 12'h000;
		reg_wr(`DPR_REG_ADDR_A + o, {23'h0, a});
		reg_wr(`DPR_REG_WDATA_A + o, {24'h0, d});
		reg_wr(`DPR_REG_BEN_A + o, {28'h0, be});
		reg_wr(`DPR_REG_CMD_A + o, {30'h0, cmd});
		repeat (4) @(posedge sys_clk_in);
		reg_rd(`DPR_REG_RDATA_A + o);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		reg_rd(`DPR_REG_STAT);
		`CHK("stat_bits", 16'h1200, rd_v[31:16])
		reg_rd(`DPR_REG_RDATA_A);
		`CHK("rdata_a", 32'h0, rd_v)
		reg_rd(`DPR_REG_RDATA_B);
		`CHK("rdata_b", 32'h0, rd_v)
		$display("t_reset done");
	endtask
	task automatic t_ports;
		reg_wr(`DPR_REG_CTRL, ctrl(3'd2, 4'd3, 5'h0));
		mem_op(1'b0, 9'd5, 8'h5A, 4'h1, 2'd3);
		`CHK("same_port_rdw", 32'h5A, rd_v)
		mem_op(1'b1, 9'd6, 8'hC3, 4'h1, 2'd1);
		mem_op(1'b0, 9'd6, 8'h00, 4'h0, 2'd2);
		`CHK("b_wr_a_rd", 32'hC3, rd_v)
		mem_op(1'b1, 9'd5, 8'h00, 4'h0, 2'd2);
		`CHK("a_wr_b_rd", 32'h5A, rd_v)
		$display("t_ports done");
	endtask
	task automatic t_ben;
		mem_op(1'b0, 9'd5, 8'hFF, 4'h0, 2'd3);
		`CHK("masked_keep", 32'h5A, rd_v)
		mem_op(1'b0, 9'd5, 8'h3C, 4'h1, 2'd3);
		`CHK("enabled_new", 32'h3C, rd_v)
		$display("t_ben done");
	endtask
	task automatic t_oreg_clr;
		reg_wr(`DPR_REG_CTRL, ctrl(3'd2, 4'd3, 5'h01));
		mem_op(1'b0, 9'd6, 8'h00, 4'h0, 2'd2);
		`CHK("oreg_read", 32'hC3, rd_v)
		reg_wr(`DPR_REG_CTRL, ctrl(3'd2, 4'd3, 5'h11));
		repeat (2) @(posedge sys_clk_in);
		reg_rd(`DPR_REG_RDATA_A);
		`CHK("cleared", 32'h0, rd_v)
		reg_wr(`DPR_REG_CMD_A, 32'h2);
		repeat (4) @(posedge sys_clk_in);
		reg_rd(`DPR_REG_RDATA_A);
		`CHK("mem_kept", 32'hC3, rd_v)
		$display("t_oreg_clr done");
	endtask
	task automatic t_hold;
		reg_wr(`DPR_REG_CTRL, ctrl(3'd2, 4'd3, 5'h04));
		mem_op(1'b0, 9'd5, 8'h00, 4'h0, 2'd2);
		`CHK("held_addr", 32'hC3, rd_v)
		reg_wr(`DPR_REG_CTRL, ctrl(3'd2, 4'd3, 5'h00));
		mem_op(1'b0, 9'd5, 8'h00, 4'h0, 2'd2);
		`CHK("released_addr", 32'h3C, rd_v)
		$display("t_hold done");
	endtask
	task automatic t_init;
		reg_wr(`DPR_REG_INIT, 32'h8000_0000 | (32'd100 << 9) | 32'h0A5);
		mem_op(1'b0, 9'd100, 8'h00, 4'h0, 2'd2);
		`CHK("preload", 32'hA5, rd_v)
		$display("t_init done");
	endtask
	task automatic t_cfg;
		for (int m = 0; m < 5; m++)
		begin
			reg_wr(`DPR_REG_CTRL, ctrl(m[2:0], 4'd6, 5'h0));
			reg_rd(`DPR_REG_STAT);
			`CHK("cfg_ok", 1'b0, rd_v[0])
			if (m == 3)
			begin
				reg_wr(`DPR_REG_CMD_A, 32'h1);
				reg_rd(`DPR_REG_STAT);
				`CHK("rom_wr_refused", 1'b1, rd_v[1])
			end
		end
		for (int w = 7; w < 9; w++)
		begin
			reg_wr(`DPR_REG_CTRL, ctrl(3'd2, w[3:0], 5'h0));
			reg_rd(`DPR_REG_STAT);
			`CHK("cfg_refused", 1'b1, rd_v[0])
			reg_wr(`DPR_REG_CMD_A, 32'h1);
			reg_rd(`DPR_REG_STAT);
			`CHK("wide_wr_refused", 1'b1, rd_v[1])
			reg_wr(`DPR_REG_CTRL, ctrl(3'd1, w[3:0], 5'h0));
			reg_wr(`DPR_REG_STAT, 32'h0);
			reg_rd(`DPR_REG_STAT);
			`CHK("cfg_wide_ok", 1'b0, rd_v[0])
		end
		$display("t_cfg done");
	endtask
	task automatic t_sdp;
		reg_wr(`DPR_REG_CTRL, ctrl(3'd1, 4'd3, 5'h0));
		mem_op(1'b1, 9'd7, 8'h77, 4'h1, 2'd1);
		mem_op(1'b0, 9'd7, 8'h11, 4'h1, 2'd1);
		reg_rd(`DPR_REG_STAT);
		`CHK("a_wr_refused", 1'b1, rd_v[1])
		mem_op(1'b0, 9'd7, 8'h00, 4'h0, 2'd2);
		`CHK("sdp_read", 32'h77, rd_v)
		$display("t_sdp done");
	endtask
	task automatic t_pack;
		reg_wr(`DPR_REG_CTRL, ctrl(3'd0, 4'd3, 5'h02));
		mem_op(1'b0, 9'd3, 8'h33, 4'h1, 2'd1);
		mem_op(1'b1, 9'd3, 8'h44, 4'h1, 2'd1);
		mem_op(1'b0, 9'd3, 8'h00, 4'h0, 2'd2);
		`CHK("pack_a", 32'h33, rd_v)
		mem_op(1'b1, 9'd3, 8'h00, 4'h0, 2'd2);
		`CHK("pack_b", 32'h44, rd_v)
		$display("t_pack done");
	endtask
	task automatic t_unmapped;
		reg_wr(12'h040, 32'hFFFF_FFFF);
		`CHK("bresp", `DPR_RESP_SLVERR, resp)
		reg_rd(12'h040);
		`CHK("rresp", `DPR_RESP_SLVERR, resp)
		`CHK("rdata", 32'h0, rd_v)
		$display("t_unmapped done");
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		nrst_in = 1'b0;
		repeat (12) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_ports();
		t_ben();
		t_oreg_clr();
		t_hold();
		t_init();
		t_cfg();
		t_sdp();
		t_pack();
		t_unmapped();
		report_and_stop();
	end
endmodule
`undef CHK
`default_nettype wire

// ==== dpr_defs.svh ====
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH
// Storage: 512 words of 9 bits = 4,608 bits including parity
`define DPR_TOTAL_BITS 4608
`define DPR_WORDS 512
`define DPR_AW 9
`define DPR_HALF_AW 8
`define DPR_MAX_W 36
`define DPR_MAX_AW 12
// Register map, byte addresses
`define DPR_REG_CTRL 12'h000
`define DPR_REG_STAT 12'h004
`define DPR_REG_ADDR_A 12'h008
`define DPR_REG_WDATA_A 12'h00C
`define DPR_REG_BEN_A 12'h010
`define DPR_REG_CMD_A 12'h014
`define DPR_REG_RDATA_A 12'h018
`define DPR_REG_ADDR_B 12'h01C
`define DPR_REG_WDATA_B 12'h020
`define DPR_REG_BEN_B 12'h024
`define DPR_REG_CMD_B 12'h028
`define DPR_REG_RDATA_B 12'h02C
`define DPR_REG_INIT 12'h030
// CTRL fields
`define DPR_CTRL_MODE_LSB 0
`define DPR_CTRL_MODE_MSB 2
`define DPR_CTRL_WID_LSB 4
`define DPR_CTRL_WID_MSB 7
`define DPR_CTRL_OREG 8
`define DPR_CTRL_PACK 9
`define DPR_CTRL_ACE_A 10
`define DPR_CTRL_ACE_B 11
`define DPR_CTRL_CLR 12
// CMD fields
`define DPR_CMD_WR 0
`define DPR_CMD_RD 1
// STAT fields
`define DPR_STAT_CFG_ERR 0
`define DPR_STAT_WR_REFUSED 1
`define DPR_STAT_FIFO_ERR 2
`define DPR_STAT_BITS_LSB 16
// INIT go bit, a one-cycle pulse
`define DPR_INIT_GO 31
`define DPR_RESP_OKAY 2'b00
`define DPR_RESP_SLVERR 2'b10
`endif

// ==== dpr_pkg.sv ====
`default_nettype none
package dpr_pkg;
	typedef enum logic [2:0] {
		DPR_SINGLE,
		DPR_SIMPLE_DUAL,
		DPR_TRUE_DUAL,
		DPR_ROM,
		DPR_FIFO
	} dpr_mode_e;
	typedef enum logic [3:0] {
		DPR_W1,
		DPR_W2,
		DPR_W4,
		DPR_W8,
		DPR_W9,
		DPR_W16,
		DPR_W18,
		DPR_W32,
		DPR_W36
	} dpr_width_e;
	typedef logic [31:0] dpr_word_t;
endpackage
`default_nettype wire

// ==== dpr_user_model.sv ====
`default_nettype none
module dpr_user_model (
	input wire logic sys_clk_in,
	output logic [11:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output dpr_pkg::dpr_word_t wdata_out,
	output logic [3:0] wstrb_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	output logic [11:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire dpr_pkg::dpr_word_t rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out
);
	import dpr_pkg::*;
	initial
	begin
		{awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end
	////////////////////////////////////////////////////////////////
	// One access at a time, so no paired fifo read and write
	task automatic wr(input logic [11:0] a, input dpr_word_t d, output logic [1:0] resp);
		logic got;
		got = 1'b0;
		@(posedge sys_clk_in);
		awaddr_out <= a;
		awvalid_out <= 1'b1;
		wdata_out <= d;
		wstrb_out <= 4'hF;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		while (!got)
		begin
			@(posedge sys_clk_in);
			if (awvalid_out && awready_in)
				awvalid_out <= 1'b0;
			if (wvalid_out && wready_in)
				wvalid_out <= 1'b0;
			if (bvalid_in)
			begin
				resp = bresp_in;
				got = 1'b1;
			end
		end
		bready_out <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output dpr_word_t d, output logic [1:0] resp);
		logic got;
		got = 1'b0;
		@(posedge sys_clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		while (!got)
		begin
			@(posedge sys_clk_in);
			if (arvalid_out && arready_in)
				arvalid_out <= 1'b0;
			if (rvalid_in)
			begin
				d = rdata_in;
				resp = rresp_in;
				got = 1'b1;
			end
		end
		rready_out <= 1'b0;
	endtask
endmodule
`default_nettype wire
